// *** i2c_ack_pin_status_ctrl.v ***
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_ack_regs.vh"

// How it works
// - ack_assert set: pull data low at ack
// - ack_assert clear: leave data high at ack
// - ack_assert clear: ignore own address, general call
// - missed ack drops slave to not addressed
// - ack_assert cleared before last byte gives C8H
// - after that disconnect, data line stays released
// - pin_pair_select picks one of two pin pairs
// - pin pair switches immediately on write
// - status code sits in bits 7:3
// - status F8H keeps interrupt flag low
// - other status codes set interrupt flag
// - status bits 2:0 read zero
// - clock held low until flag cleared
// - first byte compared with own address
module i2c_ack_pin_status_ctrl (
  input wire clk_i, // system clock
  input wire rst_i, // synchronous reset, active high
  input wire cyc_i, // wishbone cycle
  input wire stb_i, // wishbone strobe
  input wire we_i, // wishbone write
  input wire [9:0] adr_i, // wishbone byte address
  input wire [3:0] sel_i, // wishbone byte enables
  input wire [31:0] dat_i, // wishbone write data
  output reg [31:0] dat_o, // wishbone read data
  output reg ack_o, // wishbone acknowledge
  output wire irq_o, // level interrupt
  input wire pa_scl_i, // pair a clock pin
  input wire pa_sda_i, // pair a data pin
  input wire pb_scl_i, // pair b clock pin
  input wire pb_sda_i, // pair b data pin
  output wire pa_scl_o, // pair a clock drive value
  output wire pa_sda_o, // pair a data drive value
  output wire pb_scl_o, // pair b clock drive value
  output wire pb_sda_o, // pair b data drive value
  output wire pa_scl_oe_o, // pair a clock drive enable
  output wire pa_sda_oe_o, // pair a data drive enable
  output wire pb_scl_oe_o, // pair b clock drive enable
  output wire pb_sda_oe_o // pair b data drive enable
);

  localparam [1:0] PH_IDLE = 2'd0;
  localparam [1:0] PH_ADDR = 2'd1;
  localparam [1:0] PH_RX = 2'd2;
  localparam [1:0] PH_TX = 2'd3;

  // control bits held by the bus side
  reg en_q;
  reg start_q;
  reg stop_q;
  reg ack_assert_q;
  reg pin_pair_select_q;
  reg [7:0] own_slave_address_q;
  reg [1:0] irq_en_q;
  // engine state
  reg si_q;
  reg [7:0] bus_status_code_q;
  reg [7:0] data_q;
  reg [1:0] irq_sts_q;
  reg [1:0] phase_q;
  reg [3:0] bit_q;
  reg [7:0] shift_q;
  reg [7:0] tx_q;
  reg sda_low_q;
  reg gc_q;
  reg rw_q;
  reg master_ack_q;
  reg scl_p_q;
  reg sda_p_q;

  wire scl_raw;
  wire sda_raw;
  wire scl_s;
  wire sda_s;

  wire access = cyc_i & stb_i & ~ack_o;
  wire wr = access & we_i & sel_i[0];
  wire [7:0] idx = adr_i[9:2];

  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  wire wr_ctl = wr & hit(idx, `IDX_CONTROL);
  wire si_clr = wr_ctl & ~dat_i[`CTL_SI];
  wire wr_data = wr & hit(idx, `IDX_DATA);
  wire wr_irq_clr = wr & hit(idx, `IDX_IRQ_CLEAR);

  // bus events seen on the synchronised lines
  wire scl_rise = scl_s & ~scl_p_q;
  wire scl_fall = ~scl_s & scl_p_q;
  wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // first byte against own address, or general call when enabled
  wire own_hit = (shift_q[7:1] == own_slave_address_q[7:1]);
  wire gc_hit = (shift_q[7:1] == 7'h00) & own_slave_address_q[0] & ~shift_q[0];

  pin_pair_router u_router (
    .pin_pair_select_i(pin_pair_select_q),
    .scl_low_i(si_q & en_q),
    .sda_low_i(sda_low_q & en_q),
    .pa_scl_i(pa_scl_i),
    .pa_sda_i(pa_sda_i),
    .pb_scl_i(pb_scl_i),
    .pb_sda_i(pb_sda_i),
    .pa_scl_oe_o(pa_scl_oe_o),
    .pa_sda_oe_o(pa_sda_oe_o),
    .pb_scl_oe_o(pb_scl_oe_o),
    .pb_sda_oe_o(pb_sda_oe_o),
    .scl_raw_o(scl_raw),
    .sda_raw_o(sda_raw)
  );

  pin_sync3 u_sync_scl (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(scl_raw),
    .level_o(scl_s)
  );

  pin_sync3 u_sync_sda (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(sda_raw),
    .level_o(sda_s)
  );

  // open drain: drive value is always low
  assign pa_scl_o = 1'b0;
  assign pa_sda_o = 1'b0;
  assign pb_scl_o = 1'b0;
  assign pb_sda_o = 1'b0;

  assign irq_o = |(irq_sts_q & irq_en_q);

  // bus slave: control, address, enables, answer
  always @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      start_q <= 1'b0;
      stop_q <= 1'b0;
      ack_assert_q <= 1'b0;
      pin_pair_select_q <= 1'b0;
      own_slave_address_q <= `RST_OWN_ADDR;
      irq_en_q <= 2'b00;
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= access;
      if (wr_ctl) begin
        en_q <= dat_i[`CTL_EN];
        start_q <= dat_i[`CTL_START];
        stop_q <= dat_i[`CTL_STOP];
        ack_assert_q <= dat_i[`CTL_ACK_ASSERT];
        pin_pair_select_q <= dat_i[`CTL_PX];
      end else if (wr & hit(idx, `IDX_OWN_ADDR)) begin
        own_slave_address_q <= dat_i[7:0];
      end else if (wr & hit(idx, `IDX_IRQ_ENABLE)) begin
        irq_en_q <= dat_i[1:0];
      end
      if (access & ~we_i) begin
        if (hit(idx, `IDX_STATUS)) begin
          dat_o <= {24'h000000, bus_status_code_q[7:3], 3'b000};
        end else if (hit(idx, `IDX_CONTROL)) begin
          dat_o <= {24'h000000, 1'b0, en_q, start_q, stop_q, si_q, ack_assert_q, 1'b0,
                    pin_pair_select_q};
        end else if (hit(idx, `IDX_OWN_ADDR)) begin
          dat_o <= {24'h000000, own_slave_address_q};
        end else if (hit(idx, `IDX_DATA)) begin
          dat_o <= {24'h000000, data_q};
        end else if (hit(idx, `IDX_IRQ_STATUS)) begin
          dat_o <= {30'h00000000, irq_sts_q};
        end else if (hit(idx, `IDX_IRQ_ENABLE)) begin
          dat_o <= {30'h00000000, irq_en_q};
        end else begin
          dat_o <= 32'h00000000;
        end
      end else begin
        dat_o <= 32'h00000000;
      end
    end
  end

  // slave engine; a status write never reaches it
  always @(posedge clk_i) begin
    if (rst_i) begin
      si_q <= 1'b0;
      bus_status_code_q <= `RST_STATUS;
      data_q <= `RST_DATA;
      irq_sts_q <= 2'b00;
      phase_q <= PH_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'hff;
      sda_low_q <= 1'b0;
      gc_q <= 1'b0;
      rw_q <= 1'b0;
      master_ack_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (wr_data) begin
        data_q <= dat_i[7:0];
      end
      if (si_clr) begin
        si_q <= 1'b0;
        bus_status_code_q <= `ST_IDLE;
      end
      if (wr_irq_clr) begin
        irq_sts_q <= irq_sts_q & ~dat_i[1:0];
      end
      // released stretch in transmit: present first bit
      if (si_q & si_clr & (phase_q == PH_TX) & (bit_q == 4'h0)) begin
        tx_q <= wr_data ? dat_i[7:0] : data_q;
        sda_low_q <= wr_data ? ~dat_i[7] : ~data_q[7];
      end
      if (~en_q) begin
        phase_q <= PH_IDLE;
        sda_low_q <= 1'b0;
        si_q <= 1'b0;
        bus_status_code_q <= `ST_IDLE;
      end else if (bus_start) begin
        phase_q <= PH_ADDR;
        bit_q <= 4'h0;
        sda_low_q <= 1'b0;
      end else if (bus_stop) begin
        phase_q <= PH_IDLE;
        sda_low_q <= 1'b0;
      end else if (scl_rise & (phase_q != PH_IDLE)) begin
        bit_q <= bit_q + 4'h1;
        if (bit_q < 4'h8) begin
          shift_q <= {shift_q[6:0], sda_s};
        end else begin
          master_ack_q <= ~sda_s;
        end
      end else if (scl_fall & (phase_q != PH_IDLE)) begin
        if (bit_q == 4'h8) begin
          if (phase_q == PH_ADDR) begin
            if (ack_assert_q & (own_hit | gc_hit)) begin
              sda_low_q <= 1'b1;
              gc_q <= gc_hit & ~own_hit;
              rw_q <= shift_q[0];
            end else begin
              phase_q <= PH_IDLE;
              sda_low_q <= 1'b0;
            end
          end else if (phase_q == PH_RX) begin
            sda_low_q <= ack_assert_q;
          end else begin
            sda_low_q <= 1'b0;
          end
        end else if (bit_q == 4'h9) begin
          bit_q <= 4'h0;
          sda_low_q <= 1'b0;
          si_q <= 1'b1;
          irq_sts_q[`IRQ_SI] <= 1'b1;
          if (phase_q == PH_ADDR) begin
            phase_q <= rw_q ? PH_TX : PH_RX;
            bus_status_code_q <= rw_q ? `ST_SLA_R_ACK :
                                 (gc_q ? `ST_GC_ACK : `ST_SLA_W_ACK);
          end else if (phase_q == PH_RX) begin
            data_q <= shift_q;
            if (sda_low_q) begin
              bus_status_code_q <= gc_q ? `ST_GC_RX_ACK : `ST_RX_ACK;
            end else begin
              bus_status_code_q <= gc_q ? `ST_GC_RX_NACK : `ST_RX_NACK;
              phase_q <= PH_IDLE;
              irq_sts_q[`IRQ_UNADDR] <= 1'b1;
            end
          end else begin
            if (~master_ack_q) begin
              bus_status_code_q <= `ST_TX_NACK;
              phase_q <= PH_IDLE;
              irq_sts_q[`IRQ_UNADDR] <= 1'b1;
            end else if (~ack_assert_q) begin
              bus_status_code_q <= `ST_TX_LAST;
              phase_q <= PH_IDLE;
              irq_sts_q[`IRQ_UNADDR] <= 1'b1;
            end else begin
              bus_status_code_q <= `ST_TX_ACK;
            end
          end
        end else if (phase_q == PH_TX) begin
          sda_low_q <= ~tx_q[3'd7 - bit_q[2:0]];
        end
      end
    end
  end

endmodule // i2c_ack_pin_status_ctrl

`default_nettype wire

// *** i2c_ack_regs.vh ***
`ifndef I2C_ACK_REGS_VH
`define I2C_ACK_REGS_VH

// register word indices; byte address is four times the index
`define IDX_DATA 8'hbc
`define IDX_STATUS 8'hbd
`define IDX_CONTROL 8'hc0
`define IDX_OWN_ADDR 8'hc1
`define IDX_IRQ_STATUS 8'hd0
`define IDX_IRQ_ENABLE 8'hd1
`define IDX_IRQ_CLEAR 8'hd2

// bus_control field positions
`define CTL_EN 6
`define CTL_START 5
`define CTL_STOP 4
`define CTL_SI 3
`define CTL_ACK_ASSERT 2
`define CTL_PX 0

// reset values
`define RST_CONTROL 8'h00
`define RST_OWN_ADDR 8'h00
`define RST_DATA 8'h00
`define RST_STATUS 8'hf8

// status codes
`define ST_IDLE 8'hf8
`define ST_SLA_W_ACK 8'h60
`define ST_GC_ACK 8'h70
`define ST_RX_ACK 8'h80
`define ST_RX_NACK 8'h88
`define ST_GC_RX_ACK 8'h90
`define ST_GC_RX_NACK 8'h98
`define ST_SLA_R_ACK 8'ha8
`define ST_TX_ACK 8'hb8
`define ST_TX_NACK 8'hc0
`define ST_TX_LAST 8'hc8

// interrupt status bit positions
`define IRQ_SI 0
`define IRQ_UNADDR 1

`endif

// *** pin_sync3.v ***
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 (
  input wire clk_i, // system clock
  input wire rst_i, // synchronous reset, active high
  input wire pin_i, // asynchronous pin level
  output reg level_o // filtered level
);

  reg ff1_q;
  reg ff2_q;
  reg ff3_q;

  // change counts once second and third stages agree
  always @(posedge clk_i) begin
    if (rst_i) begin
      ff1_q <= 1'b1;
      ff2_q <= 1'b1;
      ff3_q <= 1'b1;
      level_o <= 1'b1;
    end else begin
      ff1_q <= pin_i;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      if (ff2_q == ff3_q) begin
        level_o <= ff3_q;
      end
    end
  end

endmodule // pin_sync3

`default_nettype wire

// *** pin_pair_router.v ***
`timescale 1ns/1ps
`default_nettype none

module pin_pair_router (
  input wire pin_pair_select_i, // 0: pair a, 1: pair b
  input wire scl_low_i, // pull clock line low
  input wire sda_low_i, // pull data line low
  input wire pa_scl_i, // pair a clock pin level
  input wire pa_sda_i, // pair a data pin level
  input wire pb_scl_i, // pair b clock pin level
  input wire pb_sda_i, // pair b data pin level
  output wire pa_scl_oe_o, // pair a clock drive enable
  output wire pa_sda_oe_o, // pair a data drive enable
  output wire pb_scl_oe_o, // pair b clock drive enable
  output wire pb_sda_oe_o, // pair b data drive enable
  output wire scl_raw_o, // selected clock level
  output wire sda_raw_o // selected data level
);

  // switches at once, no wait for an idle bus
  assign pa_scl_oe_o = ~pin_pair_select_i & scl_low_i;
  assign pa_sda_oe_o = ~pin_pair_select_i & sda_low_i;
  assign pb_scl_oe_o = pin_pair_select_i & scl_low_i;
  assign pb_sda_oe_o = pin_pair_select_i & sda_low_i;
  assign scl_raw_o = pin_pair_select_i ? pb_scl_i : pa_scl_i;
  assign sda_raw_o = pin_pair_select_i ? pb_sda_i : pa_sda_i;

endmodule // pin_pair_router

`default_nettype wire

// *** i2c_ack_pin_status_ctrl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2c_ack_chk (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic cyc_i, // cycle
  input wire logic stb_i, // strobe
  input wire logic we_i, // write
  input wire logic [9:0] adr_i, // address
  input wire logic [3:0] sel_i, // byte enables
  input wire logic [31:0] dat_i, // write data
  input wire logic [31:0] dat_o, // read data
  input wire logic ack_o, // acknowledge
  input wire logic irq_o, // interrupt
  input wire logic pa_scl_o, // drive values
  input wire logic pa_sda_o, // drive values
  input wire logic pb_scl_o, // drive values
  input wire logic pb_sda_o, // drive values
  input wire logic pa_scl_oe_o, // enables
  input wire logic pa_sda_oe_o, // enables
  input wire logic pb_scl_oe_o, // enables
  input wire logic pb_sda_oe_o // enables
);
  wire logic req = cyc_i && stb_i && !ack_o;
  wire logic wr = req && we_i && sel_i[0];
  wire logic clr_flag = wr && adr_i[9:2] == 8'hc0 && !dat_i[3];
  wire logic wr_irq = wr && (adr_i[9:2] == 8'hd1 || adr_i[9:2] == 8'hd2);
  wire logic scl_oe = pa_scl_oe_o || pb_scl_oe_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_single: assert property (ack_o |=> !ack_o) else $error("ack too long");
  chk_ack_answer: assert property (req |=> ack_o) else $error("no ack");
  chk_data_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("stray read data");
  chk_status_low: assert property (req && !we_i && adr_i[9:2] == 8'hbd |=>
    dat_o[2:0] == 3'h0 && dat_o[31:8] == 24'h0) else $error("status low bits set");
  chk_one_pair: assert property (!((pa_scl_oe_o || pa_sda_oe_o) &&
    (pb_scl_oe_o || pb_sda_oe_o))) else $error("both pairs driven");
  chk_open_drain: assert property (!(pa_scl_o || pa_sda_o || pb_scl_o || pb_sda_o))
    else $error("pin driven high");
  chk_stretch_hold: assert property ($fell(scl_oe) |-> $past(clr_flag))
    else $error("clock released early");
  chk_irq_drop: assert property ($fell(irq_o) |-> $past(wr_irq))
    else $error("irq dropped alone");
endmodule // i2c_ack_chk
bind i2c_ack_pin_status_ctrl i2c_ack_chk i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .irq_o, .pa_scl_o, .pa_sda_o, .pb_scl_o, .pb_sda_o,
  .pa_scl_oe_o, .pa_sda_oe_o, .pb_scl_oe_o, .pb_sda_oe_o);
`default_nettype wire

// *** i2c_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic scl_i, // clock line level
  input wire logic sda_i, // data line level
  output logic scl_low_o, // pull clock low
  output logic sda_low_o // pull data low
);
  integer stalls = 0;
  initial begin
    scl_low_o = 0;
    sda_low_o = 0;
  end
  // keep line changes clear of the system clock's rising edges
  task align;
    begin
      #((17 - ($time % 10)) % 10);
    end
  endtask
  // long low phase: the slave needs about five clocks to answer a fall
  task bit_io(input logic b, output logic r);
    integer n;
    begin
      sda_low_o = !b;
      #40;
      scl_low_o = 0;
      #10;
      n = 0;
      while (scl_i !== 1'b1 && n < 500) begin
        #10;
        n++;
      end
      if (n == 500) stalls++;
      #10;
      r = sda_i;
      scl_low_o = 1;
      #20;
    end
  endtask
  task send(input logic [7:0] d, output logic ack);
    integer i;
    logic r;
    begin
      align;
      for (i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1, ack);
      #60;
    end
  endtask
  task recv(output logic [7:0] d, input logic mack);
    integer i;
    logic r;
    begin
      align;
      for (i = 0; i < 8; i++) begin
        bit_io(1, r);
        d = {d[6:0], r};
      end
      bit_io(!mack, r);
      #60;
    end
  endtask
  task start;
    begin
      align;
      #40 sda_low_o = 1;
      #40 scl_low_o = 1;
      #20;
    end
  endtask
  task stop;
    begin
      align;
      sda_low_o = 1;
      #20 scl_low_o = 0;
      #40 sda_low_o = 0;
      #40;
    end
  endtask
endmodule // i2c_master_model
`default_nettype wire

// *** i2c_ack_pin_status_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module i2c_ack_pin_status_ctrl_tb;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, on_b = 0, a;
  logic [9:0] adr_i = 10'h000;
  logic [3:0] sel_i = 4'hf;
  logic [31:0] dat_i = 32'h0, rdat;
  logic [7:0] d0, r8;
  logic [7:0] tx_q[$];
  wire [31:0] dat_o;
  wire ack_o, irq_o, pa_scl_oe_o, pa_sda_oe_o, pb_scl_oe_o, pb_sda_oe_o, m_scl, m_sda;
  wire scl_w = !(m_scl | (on_b ? pb_scl_oe_o : pa_scl_oe_o));
  wire sda_w = !(m_sda | (on_b ? pb_sda_oe_o : pa_sda_oe_o));
  integer err_count = 0, samples_checked = 0, seed = 32'h74f1, k;
  always #5 clk_i = ~clk_i;
  i2c_ack_pin_status_ctrl i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .irq_o, .pa_scl_i(on_b | scl_w), .pa_sda_i(on_b | sda_w),
    .pb_scl_i(!on_b | scl_w), .pb_sda_i(!on_b | sda_w), .pa_scl_o(), .pa_sda_o(),
    .pb_scl_o(), .pb_sda_o(), .pa_scl_oe_o, .pa_sda_oe_o, .pb_scl_oe_o, .pb_sda_oe_o);
  i2c_master_model i_master (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl), .sda_low_o(m_sda));
  task close_out;
    begin
      if (err_count == 0 && samples_checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp) begin
        err_count++;
        $display("BAD %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    integer n;
    begin
      @(posedge clk_i);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h0, d};
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (ack_o !== 1'b1 && n < 20);
      rdat = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
      if (ack_o !== 1'b1) begin
        err_count++;
        close_out;
      end
    end
  endtask
  task rc(input string nm, input logic [7:0] idx, input logic [31:0] e);
    begin
      wb(0, idx, 8'h00);
      chk(nm, rdat, e);
    end
  endtask
  task sb(input logic [7:0] b, input logic ea, input logic [7:0] es);
    begin
      i_master.send(b, a);
      chk("ack", a, ea);
      rc("status", 8'hbd, es);
    end
  endtask
  task rb(input logic [7:0] e, input logic [7:0] es, input logic mack);
    begin
      i_master.recv(r8, mack);
      chk("tx", r8, e);
      rc("status", 8'hbd, es);
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    rc("st_rst", 8'hbd, 32'hf8);
    rc("ctl_rst", 8'hc0, 32'h0);
    rc("irq_rst", 8'hd0, 32'h0);
    wb(1, 8'hbd, 8'h00);
    rc("st_ro", 8'hbd, 32'hf8);
    rc("unmapped", 8'h10, 32'h0);
    wb(1, 8'hc1, 8'h55);
    wb(1, 8'hd1, 8'h01);
    wb(1, 8'hc0, 8'h44);
    i_master.start;
    sb(8'h54, 0, 8'h60);
    chk("irq", irq_o, 1);
    rc("ctl_si", 8'hc0, 32'h4c);
    wb(1, 8'hc0, 8'h44);
    d0 = $random(seed);
    sb(d0, 0, 8'h80);
    rc("rx", 8'hbc, d0);
    wb(1, 8'hc0, 8'h44);
    i_master.stop;
    i_master.start;
    sb(8'h00, 0, 8'h70);
    wb(1, 8'hc0, 8'h40);
    sb(8'h5a, 1, 8'h98);
    wb(1, 8'hc0, 8'h40);
    sb(8'ha5, 1, 8'hf8);
    i_master.stop;
    rc("irq_sts", 8'hd0, 32'h3);
    wb(1, 8'hd2, 8'h03);
    i_master.start;
    sb(8'h54, 1, 8'hf8);
    chk("irq_off", irq_o, 0);
    i_master.stop;
    wb(1, 8'hc0, 8'h44);
    i_master.start;
    sb(8'h55, 0, 8'ha8);
    for (k = 0; k < 2; k++) begin
      d0 = $random(seed);
      tx_q.push_back(d0);
      wb(1, 8'hbc, d0);
      wb(1, 8'hc0, k ? 8'h40 : 8'h44);
      rb(tx_q.pop_front(), k ? 8'hc8 : 8'hb8, 1);
    end
    wb(1, 8'hc0, 8'h40);
    rb(8'hff, 8'hf8, 0);
    i_master.stop;
    wb(1, 8'hd2, 8'h03);
    wb(1, 8'hd1, 8'h00);
    wb(1, 8'hc0, 8'h45);
    on_b <= 1;
    i_master.start;
    sb(8'h54, 0, 8'h60);
    chk("masked", irq_o, 0);
    wb(1, 8'hd1, 8'h01);
    chk("unmasked", irq_o, 1);
    wb(1, 8'hd2, 8'h01);
    chk("cleared", irq_o, 0);
    wb(1, 8'hc0, 8'h45);
    i_master.stop;
    i_master.start;
    sb(8'h55, 0, 8'ha8);
    d0 = $random(seed);
    wb(1, 8'hbc, d0);
    wb(1, 8'hc0, 8'h45);
    rb(d0, 8'hc0, 0);
    wb(1, 8'hc0, 8'h45);
    i_master.stop;
    chk("stall", i_master.stalls, 0);
    close_out;
  end
endmodule // i2c_ack_pin_status_ctrl_tb
`default_nettype wire
